// file: bench/srg_guard_tb.sv
// self-checking bench for the read checksum and map guard block
`timescale 1ns/1ps

module srg_guard_tb;
  import srg_pkg::*;
  logic mclk, rst, sck, cs_n, sdi, sdo, sdo_oe, irq_n, mod_bit, conv_ready_pulse, map_locked, m;
  logic [7:0] sample_data;
  logic [15:0] map_checksum_value, c;
  logic [31:0] rx;
  int failures, checks, cyc;

  srg_guard #(.MCLK_PER_MODULATOR_CLOCK(4), .FIFO_DEPTH(16)) uut (.mclk(mclk), .rst(rst), .sck(sck), .cs_n(cs_n),
    .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .irq_n(irq_n), .mod_bit(mod_bit),
    .conv_ready_pulse(conv_ready_pulse), .sample_data(sample_data), .map_locked(map_locked),
    .map_checksum_value(map_checksum_value));

  srg_host u_host (.mclk(mclk), .sdo(sdo), .sck(sck), .cs_n(cs_n), .sdi(sdi));

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // toggling bitstream makes any stale pin value visible
  always @(posedge mclk) mod_bit <= #1 ~mod_bit;

  // hang guard, well above the few thousand cycles the tests need
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      test_done();
    end
  end

  // independent serial checksum, msb first from zero
  function automatic logic [15:0] ref_crc(input logic [15:0] s, input logic [31:0] d, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      s = {s[14:0], 1'b0} ^ ((s[15] ^ d[i]) ? 16'h8005 : 16'h0000);
    end
    return s;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmd(input logic [3:0] a, input logic [1:0] k);
    u_host.start();
    u_host.xfer({24'h0, 2'b00, a, k}, 8, rx);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    cmd(a, CMD_WRITE);
    u_host.xfer({24'h0, d}, 8, rx);
    u_host.stop();
  endtask

  task automatic test_done();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    failures = 0;
    checks = 0;
    cyc = 0;
    rst = 1'b1;
    mod_bit = 1'b0;
    conv_ready_pulse = 1'b0;
    sample_data = 8'h3c;
    repeat (2) @(posedge mclk);
    #1 rst = 1'b0;
    chk(irq_n, 1'b1);
    chk(map_locked, 1'b0);
    chk(map_checksum_value, 16'h0000);
    $display("test reset done");
    // first frame after power-on shows the power-on flag low; enable read checksum
    cmd(ADDR_SETUP3, CMD_WRITE);
    chk(sdo_oe, 1'b1);
    chk(rx[7:0], 8'h06);
    u_host.xfer(32'h01, 8, rx);
    u_host.stop();
    chk(sdo_oe, 1'b0);
    // static read: checksum after each register, later ones cover the register only
    cmd(ADDR_SETUP3, CMD_STATIC);
    chk(rx[7:0], 8'h07);
    u_host.xfer(32'h0, 8, rx);
    chk(rx[7:0], 8'h01);
    u_host.xfer(32'h0, 16, rx);
    chk(rx[15:0], ref_crc(16'h0, 32'h0701, 16));
    chk(ref_crc(ref_crc(16'h0, 32'h0701, 16), rx, 16), 16'h0000);
    u_host.xfer(32'h0, 8, rx);
    chk(rx[7:0], 8'h01);
    u_host.xfer(32'h0, 16, rx);
    chk(rx[15:0], ref_crc(16'h0, 32'h01, 8));
    u_host.stop();
    $display("test static read done");
    // wide format pads sixteen zero bits, checksum value unchanged
    wr(ADDR_SETUP3, 8'h03);
    cmd(ADDR_SETUP3, CMD_STATIC);
    u_host.xfer(32'h0, 8, rx);
    chk(rx[7:0], 8'h03);
    u_host.xfer(32'h0, 32, rx);
    chk(rx, {ref_crc(16'h0, 32'h0703, 16), 16'h0000});
    u_host.stop();
    // disabled: registers follow each other with nothing between
    wr(ADDR_SETUP3, 8'h00);
    cmd(ADDR_SETUP3, CMD_STATIC);
    u_host.xfer(32'h0, 16, rx);
    chk(rx[15:0], 16'h0000);
    u_host.stop();
    $display("test format done");
    // bitstream mode: pin follows the modulator one flop later while no error
    wr(ADDR_IRQ, 8'h10);
    repeat (8) @(posedge mclk);
    repeat (4) begin
      @(posedge mclk);
      m = mod_bit;
      #2 chk(irq_n, m);
    end
    wr(ADDR_IRQ, 8'h00);
    $display("test bitstream done");
    // one write from 0xc runs into the key and locks the map
    wr(ADDR_SETUP3, 8'h01);
    cmd(4'hc, CMD_WRITE);
    u_host.xfer(32'h0, 8, rx);
    u_host.xfer(32'h0, 8, rx);
    u_host.stop();
    repeat (8) @(posedge mclk);
    chk(map_locked, 1'b1);
    // expected map checksum: flags as ones, checksum field as zeros
    c = 16'h0;
    for (int a = 1; a <= 14; a++) begin
      c = ref_crc(c, (a == 3) ? 32'h01 : ((a == 5) ? 32'h07 : 32'h00), 8);
    end
    c = ref_crc(c, 32'h0, 16);
    repeat (60) @(posedge mclk);
    chk(map_checksum_value, c);
    repeat (100) @(posedge mclk);
    chk(map_checksum_value, c);
    chk(irq_n, 1'b1);
    // locked: write to the setup register has no effect
    wr(ADDR_SETUP3, 8'h03);
    cmd(ADDR_SETUP3, CMD_STATIC);
    u_host.xfer(32'h0, 24, rx);
    chk(rx, {8'h00, 8'h01, ref_crc(16'h0, 32'h0701, 16)});
    u_host.stop();
    $display("test lock done");
    // incremental read from 0xe: checksum only after the 16-bit register at 0xf
    cmd(4'he, CMD_INCR);
    u_host.xfer(32'h0, 8, rx);
    chk(rx[7:0], 8'h00);
    u_host.xfer(32'h0, 16, rx);
    chk(rx[15:0], c);
    u_host.xfer(32'h0, 16, rx);
    chk(rx[15:0], ref_crc(16'h0, {8'h07, 8'h00, c}, 32));
    u_host.stop();
    $display("test incremental read done");
    // a new key value while locked breaks the map checksum and pulls the pin low
    wr(ADDR_KEY, 8'h01);
    repeat (60) @(posedge mclk);
    chk(map_locked, 1'b1);
    chk(irq_n, 1'b0);
    @(posedge mclk);
    #1 conv_ready_pulse = 1'b1;
    @(posedge mclk);
    #1 conv_ready_pulse = 1'b0;
    // status and interrupt register show the error; reading the register drops stale flags
    cmd(ADDR_IRQ, CMD_STATIC);
    chk(rx[7:0], 8'h01);
    u_host.xfer(32'h0, 8, rx);
    chk(rx[7:0], 8'h00);
    u_host.stop();
    cmd(ADDR_IRQ, CMD_STATIC);
    chk(rx[7:0], 8'h05);
    u_host.xfer(32'h0, 8, rx);
    chk(rx[7:0], 8'h05);
    u_host.stop();
    // fast start clears the error, the next recheck raises it again
    cmd(FAST_START, 2'b00);
    u_host.stop();
    repeat (60) @(posedge mclk);
    chk(irq_n, 1'b0);
    $display("test map error done");
    // unlock clears the map checksum and releases the pin
    wr(ADDR_KEY, KEY_OPEN);
    repeat (12) @(posedge mclk);
    chk(map_locked, 1'b0);
    chk(map_checksum_value, 16'h0000);
    chk(irq_n, 1'b1);
    // the status copy of the error stays until it has been read once
    cmd(ADDR_SETUP3, CMD_STATIC);
    chk(rx[7:0], 8'h05);
    u_host.stop();
    cmd(ADDR_SETUP3, CMD_STATIC);
    chk(rx[7:0], 8'h07);
    u_host.stop();
    $display("test unlock done");
    // an error in bitstream mode holds the pin low whatever the modulator does
    wr(ADDR_IRQ, 8'h10);
    wr(ADDR_KEY, 8'h00);
    repeat (60) @(posedge mclk);
    wr(ADDR_KEY, 8'h01);
    repeat (60) @(posedge mclk);
    repeat (4) begin
      @(posedge mclk);
      #2 chk(irq_n, 1'b0);
    end
    $display("test bitstream error done");
    test_done();
  end
endmodule

// file: bench/srg_host.sv
// host side model: spi mode 0 master that frames and shifts bytes to the guard block
`timescale 1ns/1ps

module srg_host (
  input wire logic mclk,
  input wire logic sdo,
  output logic sck,
  output logic cs_n,
  output logic sdi
);
  // sck idles low and only runs inside frames
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
  end

  // frame start; first status bit needs a few mclk before the first rise
  task automatic start();
    cs_n = 1'b0;
    repeat (4) @(posedge mclk);
    #1;
  endtask

  // released data line shows the inverse so a stale value never looks valid
  // select is held past the last fall so the device still sees it
  task automatic stop();
    repeat (4) @(posedge mclk);
    #1 cs_n = 1'b1;
    sdi = ~sdi;
    repeat (4) @(posedge mclk);
    #1;
  endtask

  // msb first, 160 ns sck period; sdo taken at the rising edge
  task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx);
    rx = 32'h0;
    for (int i = n - 1; i >= 0; i--) begin
      sdi = tx[i];
      repeat (4) @(posedge mclk);
      #1 sck = 1'b1;
      rx = {rx[30:0], sdo};
      repeat (4) @(posedge mclk);
      #1 sck = 1'b0;
    end
  endtask
endmodule

// file: core/srg_guard.sv
// read checksum insertion, write-protect key and locked map checksum, with its write fifo
`timescale 1ns/1ps

module srg_fifo #(parameter int W = 12, parameter int D = 16) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW:0] wp;
    logic [AW:0] rp;
  } srg_fifo_type;
  srg_fifo_type f_r, f_nxt;

  // pointers carry one extra bit so full and empty differ
  assign in_ready = (f_r.wp - f_r.rp) != (AW + 1)'(D);
  assign out_valid = f_r.wp != f_r.rp;
  assign out_data = f_r.mem[f_r.rp[AW-1:0]];

  always_comb begin
    f_nxt = f_r;
    if (in_valid && in_ready) begin
      f_nxt.mem[f_r.wp[AW-1:0]] = in_data;
      f_nxt.wp = f_r.wp + 1'b1;
    end
    if (out_valid && out_ready) begin
      f_nxt.rp = f_r.rp + 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      f_r <= '0;
    end else begin
      f_r <= f_nxt;
    end
  end
endmodule

module srg_guard import srg_pkg::*; #(
  parameter int MCLK_PER_MODULATOR_CLOCK = 4,
  parameter int FIFO_DEPTH = 16
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe,
  output logic irq_n,
  input wire logic mod_bit,
  input wire logic conv_ready_pulse,
  input wire logic [7:0] sample_data,
  output logic map_locked,
  output logic [15:0] map_checksum_value
);
  srg_core_type r, n;
  srg_wr_type push_d, pop_d;
  logic push_v, push_rdy, pop_v, tick, rise, fall, cs_fall, sdi_b, locked, fast, do_ld, crc_on;
  logic [3:0] ld_a;
  logic [15:0] ld_w, fed, cur_sum;

  // map checksum over 0x1..0xF; flags read as ones, checksum field as zeros
  function automatic logic [15:0] map_crc(input logic [15:0][7:0] cfg);
    logic [15:0] x;
    logic [7:0] b;
    x = 16'h0000;
    for (int a = 1; a < 15; a++) begin
      b = cfg[a];
      if (a == int'(ADDR_IRQ)) b[2:0] = FLAGS_SUBST;
      x = crc_byte(x, b);
    end
    map_crc = crc_byte(crc_byte(x, 8'h00), 8'h00);
  endfunction

  // value a read shows; the interrupt register shows flags active low
  function automatic logic [15:0] rd_word(input srg_core_type s, input logic [3:0] a, input logic [7:0] smp);
    case (a)
      ADDR_DATA: rd_word = {8'h00, smp};
      ADDR_IRQ: rd_word = {8'h00, s.cfg[ADDR_IRQ][7:3], ~s.irq_fl};
      ADDR_MAPSUM: rd_word = s.mapsum;
      default: rd_word = {8'h00, s.cfg[a]};
    endcase
  endfunction

  // edges come from the second and third sampling stages only
  assign rise = r.sck_s[1] & ~r.sck_s[2];
  assign fall = ~r.sck_s[1] & r.sck_s[2];
  assign cs_fall = ~r.cs_s[1] & r.cs_s[2];
  assign sdi_b = r.sdi_s[1];
  assign locked = r.cfg[ADDR_KEY] != KEY_OPEN;
  assign crc_on = r.cfg[ADDR_SETUP3][CRC_EN_BIT];
  assign tick = r.div == 8'h00;
  assign cur_sum = map_crc(r.cfg);
  assign push_d = '{addr: r.addr, data: {r.wbyte[6:0], sdi_b}};
  assign sdo = r.sh[31];
  assign sdo_oe = ~r.cs_s[1];
  assign irq_n = r.irq_n;
  assign map_locked = locked;
  assign map_checksum_value = r.mapsum;

  // writes drain one per modulator tick so the map changes in step with the checker
  srg_fifo #(.W($bits(srg_wr_type)), .D(FIFO_DEPTH)) u_fifo (
    .mclk(mclk),
    .rst(rst),
    .in_valid(push_v),
    .in_ready(push_rdy),
    .in_data(push_d),
    .out_valid(pop_v),
    .out_ready(tick),
    .out_data(pop_d)
  );

  always_comb begin
    n = r;
    push_v = 1'b0;
    fast = 1'b0;
    do_ld = 1'b0;
    ld_a = r.addr;
    ld_w = 16'h0000;
    fed = crc_bit(r.crc, r.sh[31]);
    n.sck_s = {r.sck_s[1:0], sck};
    n.cs_s = {r.cs_s[1:0], cs_n};
    n.sdi_s = {r.sdi_s[0], sdi};
    n.div = tick ? 8'(MCLK_PER_MODULATOR_CLOCK - 1) : r.div - 8'h01;
    // lock is judged when the write lands, so a queued key write counts first
    if (tick && pop_v && (pop_d.addr == ADDR_KEY || !locked) &&
        pop_d.addr != ADDR_DATA && pop_d.addr != ADDR_MAPSUM) begin
      n.cfg[pop_d.addr] = pop_d.data;
    end
    // serial side; a raised select aborts whatever is in flight
    if (r.cs_s[1]) begin
      n.st = ST_IDLE;
    end else if (cs_fall) begin
      n.st = ST_CMD;
      n.sh = {5'h00, ~r.stat_fl, 24'h000000};
      n.cnt = CNT_BYTE;
      n.crc = 16'h0000;
    end else if (rise && r.st == ST_CMD) begin
      n.cmd = {r.cmd[6:0], sdi_b};
    end else if (rise && r.st == ST_WRITE) begin
      n.wbyte = {r.wbyte[6:0], sdi_b};
      n.wcnt = r.wcnt + 3'h1;
      if (r.wcnt == 3'h7) begin
        push_v = 1'b1; // byte is lost when the fifo is full
        n.addr = (r.addr == ADDR_KEY) ? ADDR_WRAP_FIRST : r.addr + 4'h1;
      end
    end else if (fall && (r.st == ST_CMD || r.st == ST_READ || r.st == ST_CRC)) begin
      n.sh = {r.sh[30:0], 1'b0};
      n.cnt = r.cnt - 6'h01;
      if (r.st != ST_CRC) n.crc = fed;
      if (r.cnt == 6'h01) begin
        case (r.st)
          ST_CMD: begin
            n.stat_fl = 3'h0;
            n.addr = r.cmd[5:2];
            n.stat_rd = r.cmd[1:0] == CMD_STATIC;
            n.wcnt = 3'h0;
            case (r.cmd[1:0])
              CMD_STATIC, CMD_INCR: begin
                n.st = ST_READ;
                do_ld = 1'b1;
                ld_a = r.cmd[5:2];
              end
              CMD_WRITE: n.st = ST_WRITE;
              default: begin
                n.st = ST_IDLE;
                fast = r.cmd[5:2] == FAST_START;
              end
            endcase
          end
          ST_READ: begin
            if (r.addr == ADDR_IRQ) n.irq_fl = 3'h0;
            if (crc_on && (r.stat_rd || r.addr == ADDR_MAPSUM)) begin
              n.st = ST_CRC;
              n.wide = r.cfg[ADDR_SETUP3][CRC_WIDE_BIT];
              n.sh = {fed, 16'h0000};
              n.cnt = r.cfg[ADDR_SETUP3][CRC_WIDE_BIT] ? CNT_WIDE : CNT_WORD;
              n.crc = 16'h0000;
            end else begin
              do_ld = 1'b1;
              ld_a = r.stat_rd ? r.addr : r.addr + 4'h1;
            end
          end
          default: begin
            n.st = ST_READ;
            do_ld = 1'b1;
            ld_a = r.stat_rd ? r.addr : r.addr + 4'h1;
          end
        endcase
      end
    end
    // fast start clears the error before the checker runs, so a mismatch in the same cycle still sets it
    if (fast) n.map_err = 1'b0;
    // map checker; unlocking wipes reference, value and error
    if (!locked) begin
      n.per = 4'h0;
      n.ref_ok = 1'b0;
      n.mapsum = 16'h0000;
      n.map_err = 1'b0;
    end else if (tick) begin
      n.per = (r.per == CHECK_LAST) ? 4'h0 : r.per + 4'h1;
      if (r.per == CHECK_LAST) begin
        n.mapsum = cur_sum;
        if (!r.ref_ok) begin
          n.ref_ok = 1'b1;
          n.refsum = cur_sum;
        end else if (cur_sum != r.refsum) begin
          n.map_err = 1'b1;
        end
      end
    end
    // new events win over a clear in the same cycle
    n.stat_fl = n.stat_fl | {conv_ready_pulse, r.map_err, 1'b0};
    n.irq_fl = n.irq_fl | {conv_ready_pulse, r.map_err, 1'b0};
    n.irq_n = (r.cfg[ADDR_IRQ][MODULATOR_BITSTREAM_OUT_SEL_BIT] ? mod_bit : 1'b1) & ~n.map_err;
    // each register value is latched as its first bit goes out
    if (do_ld) begin
      n.addr = ld_a;
      ld_w = rd_word(n, ld_a, sample_data);
      n.sh = (ld_a == ADDR_MAPSUM) ? {ld_w, 16'h0000} : {ld_w[7:0], 24'h000000};
      n.cnt = (ld_a == ADDR_MAPSUM) ? CNT_WORD : CNT_BYTE;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      r <= '0;
      r.st <= ST_IDLE;
      r.cs_s <= 3'h7;
      r.cfg[ADDR_KEY] <= KEY_OPEN;
      r.stat_fl <= FLAGS_RESET;
      r.irq_fl <= FLAGS_RESET;
      r.irq_n <= 1'b1;
    end else begin
      r <= n;
    end
  end

  localparam int FIRST_MAX = int'(CHECK_PERIODS) * MCLK_PER_MODULATOR_CLOCK + 2;

  default clocking dc @(posedge mclk); endclocking
  default disable iff (rst);

  key_after_reset_a: assert property ($past(rst) |-> r.cfg[ADDR_KEY] == KEY_OPEN)
    else $error("key not open after reset");
  unlocked_clear_a: assert property (!locked |=> (r.mapsum == 16'h0000 && !r.ref_ok && !r.map_err))
    else $error("map checksum not cleared while unlocked");
  first_ref_a: assert property ($rose(locked) |-> ##[1:FIRST_MAX] (r.ref_ok || !locked))
    else $error("first map checksum late");
  ref_keep_a: assert property ((r.ref_ok && locked) |=> $stable(r.refsum))
    else $error("reference changed while locked");
  err_on_mismatch_a: assert property ((locked && r.ref_ok && tick && r.per == CHECK_LAST &&
      cur_sum != r.refsum) |=> r.map_err)
    else $error("mismatch not flagged");
  err_hold_a: assert property ((r.map_err && locked && !fast) |=> (r.map_err && !irq_n))
    else $error("map error or pin dropped while locked");
  pin_release_a: assert property ((!locked && !r.cfg[ADDR_IRQ][MODULATOR_BITSTREAM_OUT_SEL_BIT]) |=> irq_n)
    else $error("pin not released on unlock");
  bitstream_override_a: assert property ((r.map_err && locked && !fast && r.cfg[ADDR_IRQ][MODULATOR_BITSTREAM_OUT_SEL_BIT]) |=> !irq_n)
    else $error("bitstream not overridden");
  fast_clear_a: assert property ((fast && !(tick && r.per == CHECK_LAST)) |=> !r.map_err)
    else $error("fast start did not clear map error");
  static_crc_a: assert property ((fall && !r.cs_s[1] && r.st == ST_READ && r.cnt == 6'h01 &&
      r.stat_rd && crc_on) |=> r.st == ST_CRC)
    else $error("static read missed checksum");
  incr_skip_a: assert property ((fall && !r.cs_s[1] && r.st == ST_READ && r.cnt == 6'h01 &&
      !r.stat_rd && r.addr != ADDR_MAPSUM) |=> r.st == ST_READ)
    else $error("checksum inserted mid loop");
  crc_off_a: assert property ((r.st == ST_READ && !crc_on) |=> r.st != ST_CRC)
    else $error("checksum sent while disabled");
  pad_zero_a: assert property ((r.st == ST_CRC && r.wide && r.cnt <= 6'h10) |-> !sdo)
    else $error("padding bit not zero");
  crc_fresh_a: assert property ((r.st != ST_CRC ##1 r.st == ST_CRC) |-> r.crc == 16'h0000)
    else $error("checksum not restarted");
  locked_write_a: assert property ((tick && pop_v && locked && pop_d.addr != ADDR_KEY) |=> $stable(r.cfg))
    else $error("write landed while locked");

  cover_ref_cp: cover property ($rose(r.ref_ok));
  cover_err_cp: cover property ($rose(r.map_err));
  cover_wide_cp: cover property (r.st == ST_CRC && r.wide);
  cover_full_cp: cover property (!push_rdy);
  cover_fast_cp: cover property (fast && r.map_err);
endmodule

// file: core/srg_pkg.sv
// constants, carrier types and checksum helpers for the serial read checksum and map guard
// How it works
// - enable bit appends checksum after read sequences
// - both checksums use polynomial 0x8005
// - static read: checksum after every register
// - incremental read: checksum only after address 0xF
// - first checksum covers status; later, since previous
// - width select 1 adds sixteen zero bits
// - checksum value independent of output width
// - key 0xA5 at 0xD means unlocked
// - key resets to 0xA5, map starts unlocked
// - locked map ignores writes except key
// - write loop ends at key register
// - map checksum over 0x1..0xF into 0xF
// - unlocked: map checksum zero, not computed
// - flags as ones, checksum field as zeros
// - first map checksum latched as reference
// - recheck every 11 periods against reference
// - mismatch flags status, interrupt register, pin
// - unlock frees pin; copies clear on read
// - error forces pin low in bitstream mode
// - error absent at power-up until locked
// - command 11 incremental, 01 static read
// - interrupt register latched, cleared after read
// - fast start command clears map error
package srg_pkg;
  localparam logic [15:0] CRC_POLY = 16'h8005;
  localparam logic [3:0] CHECK_PERIODS = 4'hb;
  localparam logic [3:0] CHECK_LAST = CHECK_PERIODS - 4'h1;
  localparam logic [3:0] ADDR_DATA = 4'h0;
  localparam logic [3:0] ADDR_WRAP_FIRST = 4'h1;
  localparam logic [3:0] ADDR_SETUP3 = 4'h3;
  localparam logic [3:0] ADDR_IRQ = 4'h5;
  localparam logic [3:0] ADDR_KEY = 4'hd;
  localparam logic [3:0] ADDR_MAPSUM = 4'hf;
  localparam logic [7:0] KEY_OPEN = 8'ha5;
  localparam int CRC_EN_BIT = 0;
  localparam int CRC_WIDE_BIT = 1;
  localparam int MODULATOR_BITSTREAM_OUT_SEL_BIT = 4;
  localparam logic [1:0] CMD_STATIC = 2'h1;
  localparam logic [1:0] CMD_WRITE = 2'h2;
  localparam logic [1:0] CMD_INCR = 2'h3;
  localparam logic [3:0] FAST_START = 4'ha;
  localparam logic [5:0] CNT_BYTE = 6'h08;
  localparam logic [5:0] CNT_WORD = 6'h10;
  localparam logic [5:0] CNT_WIDE = 6'h20;
  localparam logic [2:0] FLAGS_RESET = 3'h1;
  localparam logic [2:0] FLAGS_SUBST = 3'h7;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01, ST_CMD = 5'h02, ST_READ = 5'h04, ST_CRC = 5'h08, ST_WRITE = 5'h10
  } srg_state_type;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] data;
  } srg_wr_type;

  // flags are [2] conversion ready, [1] map error, [0] power-on
  typedef struct packed {
    logic [2:0] sck_s;
    logic [2:0] cs_s;
    logic [1:0] sdi_s;
    srg_state_type st;
    logic [31:0] sh;
    logic [5:0] cnt;
    logic [7:0] cmd;
    logic [3:0] addr;
    logic stat_rd;
    logic wide;
    logic [15:0] crc;
    logic [2:0] wcnt;
    logic [7:0] wbyte;
    logic [15:0][7:0] cfg;
    logic [7:0] div;
    logic [3:0] per;
    logic ref_ok;
    logic [15:0] refsum;
    logic [15:0] mapsum;
    logic map_err;
    logic [2:0] stat_fl;
    logic [2:0] irq_fl;
    logic irq_n;
  } srg_core_type;

  // one serial step, msb first, zero start, no final inversion
  function automatic logic [15:0] crc_bit(input logic [15:0] c, input logic b);
    crc_bit = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? CRC_POLY : 16'h0000);
  endfunction

  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] x;
    x = c;
    for (int i = 7; i >= 0; i--) begin
      x = crc_bit(x, d[i]);
    end
    crc_byte = x;
  endfunction
endpackage
